/* sfw_host.sv */
`timescale 1ns/100ps
// Behaviour
// - Controller resends matching byte until the echo comes back, halting after MAX_SYNC_TRIES (16) unanswered tries.
// - Third byte is the baud code, initial-rate code even without change.
// - Write command sent at new rate as fifth byte, echoed as sixth.
// - Password-count address high then low, no reply, silent halt on error.
// - Compare start address high then low, no reply, silent halt on error.
// - N password bytes follow; mismatch halts the device silently.
// - Blank part skips comparison; controller sends no password string.
// - Both addresses are still sent for a blank part.
// - Controller awaits the two checksum bytes after the end record.
// - Recovery from halt is device reset and restart from matching byte.
module sfw_host import sfw_pkg::*; #(
    parameter int DIVW = 16,
    parameter int BAUD_DIV_INIT = CLK_HZ / INIT_BPS,
    parameter int BOOT_WAIT_CYC = 1_000_000,
    parameter int SYNC_GAP_CYC = 200_000,
    parameter int REPLY_TMO_CYC = 5_000_000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Session control
    input wire logic start_i,
    input wire logic [7:0] baud_code_i,
    input wire logic [DIVW-1:0] baud_div_i,
    input wire logic [15:0] pw_count_addr_i,
    input wire logic [15:0] pw_start_addr_i,
    input wire logic blank_i,
    input wire logic [7:0] pw_len_i,
    // Password byte stream
    input wire logic pw_valid_i,
    input wire logic [7:0] pw_data_i,
    output logic pw_ready_o,
    // Hex record byte stream
    input wire logic rec_valid_i,
    input wire logic [7:0] rec_data_i,
    input wire logic rec_last_i,
    output logic rec_ready_o,
    // Session status
    output logic busy_o,
    output logic done_o,
    output logic [15:0] sum_o,
    output logic halted_o,
    output logic [7:0] err_code_o,
    // Device pins
    output logic dev_rst_n_o,
    output logic txd_o,
    input wire logic rxd_i
);
    typedef enum {
        ST_IDLE, ST_RESET, ST_BOOT, ST_SYNC_TX, ST_SYNC_RX, ST_BAUD_TX, ST_BAUD_RX,
        ST_CMD_TX, ST_CMD_RX, ST_ADDR_TX, ST_PW_TX, ST_REC_TX, ST_SUM_HI, ST_SUM_LO,
        ST_DRAIN, ST_HALT
    } sfw_state_t;

    typedef struct packed {
        sfw_state_t state;
        logic [DIVW-1:0] div;
        logic [31:0] tmr;
        logic [7:0] cnt;
        logic [2:0] idx;
        logic [31:0] addr;
        logic [15:0] sum;
        logic [7:0] err_code;
        logic linked;
        logic done;
        logic dev_rst_n;
    } sfw_host_st_t;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    sfw_host_st_t st_ff;
    sfw_host_st_t nxt_st;
    logic tx_start;
    logic [7:0] tx_data;
    logic tx_busy;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_err;
    logic tmr_out;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    sfw_uart #(.DIVW(DIVW)) u_uart (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .div_i(st_ff.div),
        .tx_start_i(tx_start),
        .tx_data_i(tx_data),
        .tx_busy_o(tx_busy),
        .txd_o(txd_o),
        .rxd_i(rxd_i),
        .rx_valid_o(rx_valid),
        .rx_data_o(rx_data),
        .rx_err_o(rx_err)
    );

    assign tmr_out = (st_ff.tmr == '0);
    assign pw_ready_o = (st_ff.state == ST_PW_TX) && !tx_busy;
    assign rec_ready_o = (st_ff.state == ST_REC_TX) && !tx_busy;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        tx_start = 1'b0;
        tx_data = BYTE_NONE;
        if (!tmr_out) begin
            nxt_st.tmr = st_ff.tmr - 1'b1;
        end
        unique case (st_ff.state)
            ST_IDLE, ST_HALT: begin
                if (start_i) begin
                    nxt_st.addr = {pw_count_addr_i, pw_start_addr_i};
                    nxt_st.err_code = BYTE_NONE;
                    if (st_ff.linked && st_ff.state == ST_IDLE) begin
                        nxt_st.state = ST_CMD_TX;
                    end else begin
                        // Any halt is only left through a device reset
                        nxt_st.state = ST_RESET;
                        nxt_st.linked = 1'b0;
                        nxt_st.dev_rst_n = 1'b0;
                        nxt_st.div = DIVW'(BAUD_DIV_INIT);
                        nxt_st.tmr = 32'(RST_PULSE_CYC - 1);
                    end
                end
            end
            ST_RESET: begin
                if (tmr_out) begin
                    nxt_st.dev_rst_n = 1'b1;
                    nxt_st.tmr = 32'(BOOT_WAIT_CYC);
                    nxt_st.cnt = MAX_SYNC_TRIES;
                    nxt_st.state = ST_BOOT;
                end
            end
            ST_BOOT: begin
                if (tmr_out) begin
                    nxt_st.state = ST_SYNC_TX;
                end
            end
            ST_SYNC_TX: begin
                if (!tx_busy) begin
                    tx_start = 1'b1;
                    tx_data = BYTE_MATCH;
                    nxt_st.cnt = st_ff.cnt - 1'b1;
                    nxt_st.tmr = 32'(SYNC_GAP_CYC);
                    nxt_st.state = ST_SYNC_RX;
                end
            end
            ST_SYNC_RX: begin
                if (rx_valid && rx_data == BYTE_MATCH) begin
                    nxt_st.state = ST_BAUD_TX;
                end else if (tmr_out || rx_valid || rx_err) begin
                    // No echo yet: keep offering the matching byte
                    nxt_st.state = (st_ff.cnt == '0) ? ST_HALT : ST_SYNC_TX;
                end
            end
            ST_BAUD_TX: begin
                if (!tx_busy) begin
                    tx_start = 1'b1;
                    tx_data = baud_code_i;
                    nxt_st.tmr = 32'(REPLY_TMO_CYC);
                    nxt_st.state = ST_BAUD_RX;
                end
            end
            ST_BAUD_RX: begin
                if (rx_valid && rx_data == baud_code_i) begin
                    // Rate moves only once the echo is fully in
                    nxt_st.div = baud_div_i;
                    nxt_st.linked = 1'b1;
                    nxt_st.state = ST_CMD_TX;
                end else if (rx_valid) begin
                    nxt_st.err_code = rx_data;
                    nxt_st.tmr = 32'(SYNC_GAP_CYC);
                    nxt_st.state = ST_DRAIN;
                end else if (tmr_out || rx_err) begin
                    nxt_st.state = ST_HALT;
                end
            end
            ST_CMD_TX: begin
                if (!tx_busy) begin
                    tx_start = 1'b1;
                    tx_data = BYTE_CMD_WRITE;
                    nxt_st.tmr = 32'(REPLY_TMO_CYC);
                    nxt_st.state = ST_CMD_RX;
                end
            end
            ST_CMD_RX: begin
                if (rx_valid && rx_data == BYTE_CMD_WRITE) begin
                    nxt_st.idx = 3'h0;
                    nxt_st.state = ST_ADDR_TX;
                end else if (rx_valid) begin
                    nxt_st.err_code = rx_data;
                    nxt_st.tmr = 32'(SYNC_GAP_CYC);
                    nxt_st.state = ST_DRAIN;
                end else if (tmr_out || rx_err) begin
                    nxt_st.state = ST_HALT;
                end
            end
            ST_ADDR_TX: begin
                // Both addresses go out even for a blank part
                if (!tx_busy) begin
                    tx_start = 1'b1;
                    tx_data = st_ff.addr[31:24];
                    nxt_st.addr = {st_ff.addr[23:0], 8'h00};
                    nxt_st.idx = st_ff.idx + 1'b1;
                    if (st_ff.idx == ADDR_BYTES - 1'b1) begin
                        nxt_st.cnt = pw_len_i;
                        nxt_st.state = (blank_i || pw_len_i == '0) ? ST_REC_TX : ST_PW_TX;
                    end
                end
            end
            ST_PW_TX: begin
                if (!tx_busy && pw_valid_i) begin
                    tx_start = 1'b1;
                    tx_data = pw_data_i;
                    nxt_st.cnt = st_ff.cnt - 1'b1;
                    if (st_ff.cnt == 8'h01) begin
                        nxt_st.state = ST_REC_TX;
                    end
                end
            end
            ST_REC_TX: begin
                // Records pass verbatim; the device answers nothing until the end record
                if (!tx_busy && rec_valid_i) begin
                    tx_start = 1'b1;
                    tx_data = rec_data_i;
                    if (rec_last_i) begin
                        nxt_st.tmr = 32'(REPLY_TMO_CYC);
                        nxt_st.state = ST_SUM_HI;
                    end
                end
            end
            ST_SUM_HI: begin
                // Silence here means the device halted on the way
                if (rx_valid) begin
                    nxt_st.cnt = rx_data;
                    nxt_st.tmr = 32'(REPLY_TMO_CYC);
                    nxt_st.state = ST_SUM_LO;
                end else if (tmr_out || rx_err) begin
                    nxt_st.state = ST_HALT;
                end
            end
            ST_SUM_LO: begin
                if (rx_valid) begin
                    nxt_st.sum = {st_ff.cnt, rx_data};
                    nxt_st.done = 1'b1;
                    nxt_st.state = ST_IDLE;
                end else if (tmr_out || rx_err) begin
                    nxt_st.state = ST_HALT;
                end
            end
            ST_DRAIN: begin
                // Keep the last error byte; the run of nine ends in silence
                if (rx_valid) begin
                    nxt_st.err_code = rx_data;
                    nxt_st.tmr = 32'(SYNC_GAP_CYC);
                end else if (tmr_out) begin
                    nxt_st.linked = 1'b0;
                    nxt_st.state = ST_HALT;
                end
            end
        endcase
        if (nxt_st.state == ST_HALT) begin
            nxt_st.linked = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{state: ST_IDLE, div: DIVW'(BAUD_DIV_INIT), dev_rst_n: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy_o = (st_ff.state != ST_IDLE) && (st_ff.state != ST_HALT);
    assign done_o = st_ff.done;
    assign sum_o = st_ff.sum;
    assign halted_o = (st_ff.state == ST_HALT);
    assign err_code_o = st_ff.err_code;
    assign dev_rst_n_o = st_ff.dev_rst_n;
endmodule // sfw_host

/* sfw_pkg.sv */
package sfw_pkg;
    // Protocol bytes on the serial link
    localparam logic [7:0] BYTE_MATCH = 8'h5a;
    localparam logic [7:0] BYTE_CMD_WRITE = 8'h30;
    localparam logic [7:0] BYTE_BAUD_INIT = 8'h28;
    localparam logic [7:0] BYTE_ERR_LEAD = 8'ha1;
    localparam logic [7:0] BYTE_ERR_MID = 8'ha3;
    localparam logic [7:0] BYTE_ERR_BAUD = 8'h62;
    localparam logic [7:0] BYTE_ERR_CMD = 8'h63;
    localparam logic [7:0] BYTE_REC_START = 8'h3a;
    localparam logic [7:0] BYTE_NONE = 8'h00;
    // Clock and rates
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_NS = 10;
    localparam int INIT_BPS = 9600;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // Session shape
    localparam logic [2:0] ADDR_BYTES = 3'h4;
    localparam logic [7:0] MAX_SYNC_TRIES = 8'h10;
    // UART frame: start, 8 data, stop
    localparam logic [3:0] UART_STOP_BIT = 4'h9;
    localparam logic [9:0] UART_IDLE_FRAME = 10'h3ff;
endpackage

/* sfw_uart.sv */
`timescale 1ns/100ps
module sfw_uart import sfw_pkg::*; #(
    parameter int DIVW = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bit period in clock cycles
    input wire logic [DIVW-1:0] div_i,
    // Transmit side
    input wire logic tx_start_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_busy_o,
    output logic txd_o,
    // Receive side
    input wire logic rxd_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_err_o
);
    typedef struct packed {
        logic tx_act;
        logic [DIVW-1:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic txd;
        logic rx_act;
        logic [DIVW-1:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_valid;
        logic rx_err;
    } sfw_uart_st_t;

    sfw_uart_st_t st_ff;
    sfw_uart_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_valid = 1'b0;
        nxt_st.rx_err = 1'b0;
        if (!st_ff.tx_act) begin
            nxt_st.txd = 1'b1;
            if (tx_start_i) begin
                nxt_st.tx_act = 1'b1;
                nxt_st.tx_sh = {1'b1, tx_data_i, 1'b0};
                nxt_st.tx_cnt = div_i - 1'b1;
                nxt_st.tx_bit = 4'h0;
                nxt_st.txd = 1'b0;
            end
        end else if (st_ff.tx_cnt != '0) begin
            nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
        end else if (st_ff.tx_bit == UART_STOP_BIT) begin
            nxt_st.tx_act = 1'b0;
            nxt_st.tx_sh = UART_IDLE_FRAME;
        end else begin
            nxt_st.tx_bit = st_ff.tx_bit + 1'b1;
            nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
            nxt_st.txd = st_ff.tx_sh[1];
            nxt_st.tx_cnt = div_i - 1'b1;
        end
        // Receiver samples mid-bit, counted from the falling start edge
        if (!st_ff.rx_act) begin
            if (!rxd_i) begin
                nxt_st.rx_act = 1'b1;
                nxt_st.rx_cnt = div_i >> 1;
                nxt_st.rx_bit = 4'h0;
            end
        end else if (st_ff.rx_cnt != '0) begin
            nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
        end else begin
            nxt_st.rx_cnt = div_i - 1'b1;
            nxt_st.rx_bit = st_ff.rx_bit + 1'b1;
            if (st_ff.rx_bit == 4'h0) begin
                // Glitch, not a start bit
                nxt_st.rx_act = !rxd_i;
            end else if (st_ff.rx_bit == UART_STOP_BIT) begin
                nxt_st.rx_act = 1'b0;
                nxt_st.rx_valid = rxd_i;
                nxt_st.rx_err = !rxd_i;
            end else begin
                nxt_st.rx_sh = {rxd_i, st_ff.rx_sh[7:1]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '{tx_sh: UART_IDLE_FRAME, txd: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tx_busy_o = st_ff.tx_act;
    assign txd_o = st_ff.txd;
    assign rx_valid_o = st_ff.rx_valid;
    assign rx_data_o = st_ff.rx_sh;
    assign rx_err_o = st_ff.rx_err;
endmodule // sfw_uart

/* sfw_host_chk_sva.sv */
`timescale 1ns/100ps
module sfw_host_chk import sfw_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Session
    input wire logic start_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [15:0] sum_o,
    input wire logic halted_o,
    // Streams
    input wire logic pw_valid_i,
    input wire logic pw_ready_o,
    input wire logic rec_valid_i,
    input wire logic rec_ready_o,
    // Device pins
    input wire logic dev_rst_n_o,
    input wire logic txd_o
);
    logic [7:0] low_ff;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_ff <= 8'h00;
        end else begin
            low_ff <= dev_rst_n_o ? 8'h00 : low_ff + 8'h01;
        end
    end
    sequence s_boot;
        $rose(dev_rst_n_o);
    endsequence
    sequence s_take;
        start_i && !busy_o;
    endsequence
    AST_RST_LEN: assert property (s_boot |-> low_ff == 8'(RST_PULSE_CYC))
        else $error("device reset pulse has wrong length");
    AST_HALT_RESTART: assert property (halted_o && start_i |-> ##[1:2] !dev_rst_n_o)
        else $error("restart from halt did not reset the device");
    AST_BOOT_QUIET: assert property (s_boot |-> txd_o [*8])
        else $error("line not idle after device reset");
    AST_RST_QUIET: assert property (!dev_rst_n_o |-> txd_o)
        else $error("sending while device held in reset");
    AST_START_BUSY: assert property (s_take |=> busy_o)
        else $error("session start not taken");
    AST_DONE_ONE: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    AST_DONE_END: assert property (done_o |-> ##[0:1] (!busy_o && !halted_o))
        else $error("session not closed after checksum");
    AST_DONE_SUM: assert property ($changed(sum_o) |-> ##[0:1] (done_o || $past(done_o)))
        else $error("checksum changed without done");
    AST_HALT_IDLE: assert property (halted_o |-> !busy_o && txd_o)
        else $error("activity while halted");
    AST_PW_ONE: assert property (pw_valid_i && pw_ready_o |=> !pw_ready_o [*4])
        else $error("password byte taken twice");
    AST_REC_ONE: assert property (rec_valid_i && rec_ready_o |=> !rec_ready_o [*4])
        else $error("record byte taken twice");
    AST_READY_EXCL: assert property (!(pw_ready_o && rec_ready_o))
        else $error("both streams ready at once");
endmodule // sfw_host_chk

bind sfw_host sfw_host_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .busy_o(busy_o),
    .done_o(done_o), .sum_o(sum_o), .halted_o(halted_o), .pw_valid_i(pw_valid_i), .pw_ready_o(pw_ready_o),
    .rec_valid_i(rec_valid_i), .rec_ready_o(rec_ready_o), .dev_rst_n_o(dev_rst_n_o), .txd_o(txd_o));

/* sfw_dev_model.sv */
`timescale 1ns/100ps
module sfw_dev_model import sfw_pkg::*; #(
    parameter int INIT_DIV = 16,
    parameter logic [7:0] FAST_CODE = 8'h18,
    parameter int FAST_DIV = 8,
    parameter logic [31:0] ADDRS = 32'h01200130
) (
    // Pins
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rxd_i,
    output logic txd_o,
    // Scenario knobs
    input wire logic blank_i,
    input wire logic [3:0] miss_i,
    input wire logic reject_cmd_i,
    input wire logic [7:0] lag_i
);
    logic [7:0] pw_mem [2] = '{8'hc3, 8'h5e};
    logic [7:0] b, len, typ, cs;
    logic [15:0] sum;
    logic [31:0] a;
    int div, k;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic halt_now;
        forever @(posedge clk_i);
    endtask
    task automatic get(output logic [7:0] d);
        while (rxd_i) tick(1);
        tick(div / 2);
        for (int i = 0; i < 8; i++) begin
            tick(div);
            d[i] = rxd_i;
        end
        tick(div);
        if (!rxd_i) halt_now;
    endtask
    task automatic put(input logic [7:0] d);
        tick(lag_i + div / 2);
        for (int i = 0; i < 9; i++) begin
            txd_o <= i == 0 ? 1'b0 : d[i - 1];
            tick(div);
        end
        txd_o <= 1'b1;
        // Short stop tail so a prompt next frame from the host is not missed
        tick(div / 2 - 2);
    endtask
    task automatic err_run(input logic [7:0] code);
        for (int i = 0; i < 9; i++) put(i < 3 ? BYTE_ERR_LEAD : i < 6 ? BYTE_ERR_MID : code);
        halt_now;
    endtask
    always @(negedge rst_n_i) disable run;
    always begin : run
        txd_o <= 1'b1;
        div = INIT_DIV;
        @(posedge clk_i);
        wait (rst_n_i === 1'b1);
        k = 0;
        do begin
            get(b);
            k++;
        end while (b != BYTE_MATCH || k <= miss_i);
        put(BYTE_MATCH);
        get(b);
        if (b != BYTE_BAUD_INIT && b != FAST_CODE) err_run(BYTE_ERR_BAUD);
        put(b);
        if (b == FAST_CODE) div = FAST_DIV;
        forever begin
            get(b);
            if (b != BYTE_CMD_WRITE || reject_cmd_i) err_run(BYTE_ERR_CMD);
            put(b);
            sum = 16'h0000;
            for (int i = 0; i < 4; i++) begin
                get(b);
                a = {a[23:0], b};
            end
            if (a != ADDRS) halt_now;
            if (!blank_i) for (int i = 0; i < 2; i++) begin
                get(b);
                if (b != pw_mem[i]) halt_now;
            end
            do begin
                do get(b); while (b != BYTE_REC_START);
                get(len);
                cs = len;
                for (int i = 0; i < 3; i++) begin
                    get(typ);
                    cs += typ;
                end
                for (int i = 0; i < len; i++) begin
                    get(b);
                    cs += b;
                    sum += {8'h00, b};
                end
                get(b);
                if (cs + b != 8'h00) halt_now;
            end while (typ != 8'h01);
            put(sum[15:8]);
            put(sum[7:0]);
        end
    end
endmodule // sfw_dev_model

/* test_sfw_host.sv */
`timescale 1ns/100ps
module test_sfw_host import sfw_pkg::*;;
    localparam int LIM = 20000;
    logic clk_i = 0, rstn_i = 0, start_i = 0, blank_i = 0, pw_valid_i = 0, rec_valid_i = 0, rec_last_i = 0;
    logic [7:0] baud_code_i = 8'h18, pw_len_i = 8'h02, pw_data_i = 8'h00, rec_data_i = 8'h00, lag = 8'h00;
    logic [15:0] baud_div_i = 16'h0008, pw_count_addr_i = 16'h0120, pw_start_addr_i = 16'h0130;
    logic pw_ready_o, rec_ready_o, busy_o, done_o, halted_o, dev_rst_n_o, txd_o, rxd_i, seen_done, seen_pw;
    logic [15:0] sum_o;
    logic [7:0] err_code_o;
    logic [3:0] miss = 4'h2;
    logic reject = 1'b0;
    int fail_count = 0, checks = 0;
    logic [7:0] recs [15] = '{8'h55, 8'h3a, 8'h02, 8'h00, 8'h10, 8'h00, 8'h11, 8'h22, 8'hbb,
        8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
    sfw_host #(.DIVW(16), .BAUD_DIV_INIT(16), .BOOT_WAIT_CYC(50), .SYNC_GAP_CYC(400), .REPLY_TMO_CYC(2000)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .baud_code_i(baud_code_i), .baud_div_i(baud_div_i),
        .pw_count_addr_i(pw_count_addr_i), .pw_start_addr_i(pw_start_addr_i), .blank_i(blank_i),
        .pw_len_i(pw_len_i), .pw_valid_i(pw_valid_i), .pw_data_i(pw_data_i), .pw_ready_o(pw_ready_o),
        .rec_valid_i(rec_valid_i), .rec_data_i(rec_data_i), .rec_last_i(rec_last_i), .rec_ready_o(rec_ready_o),
        .busy_o(busy_o), .done_o(done_o), .sum_o(sum_o), .halted_o(halted_o), .err_code_o(err_code_o),
        .dev_rst_n_o(dev_rst_n_o), .txd_o(txd_o), .rxd_i(rxd_i));
    sfw_dev_model dev (.clk_i(clk_i), .rst_n_i(dev_rst_n_o), .rxd_i(txd_o), .txd_o(rxd_i), .blank_i(blank_i),
        .miss_i(miss), .reject_cmd_i(reject), .lag_i(lag));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (done_o === 1'b1) seen_done <= 1'b1;
        if (pw_ready_o === 1'b1) seen_pw <= 1'b1;
    end
    task automatic end_of_test;
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bound(input int n);
        if (n >= LIM) begin
            chk("wait", 16'h0000, 16'h0001);
            end_of_test;
        end
    endtask
    // Valid stays up between bytes so no strobe is written twice in one step
    task automatic push(input bit r, input logic [7:0] d, input logic l);
        int n;
        n = 0;
        if (r) begin
            rec_valid_i = 1'b1;
            rec_data_i = d;
            rec_last_i = l;
        end else begin
            pw_valid_i = 1'b1;
            pw_data_i = d;
        end
        while ((r ? rec_ready_o : pw_ready_o) !== 1'b1 && n < LIM) begin
            @(negedge clk_i);
            n++;
        end
        bound(n);
        @(negedge clk_i);
    endtask
    task automatic go(input bit feed, input logic [7:0] pw1, input logic [7:0] cs);
        int n;
        seen_done = 1'b0;
        seen_pw = 1'b0;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        if (feed) begin
            if (!blank_i) begin
                push(0, 8'hc3, 0);
                push(0, pw1, 0);
            end
            pw_valid_i = 1'b0;
            for (int i = 0; i < 15; i++) push(1, i == 8 ? cs : recs[i], i == 14);
            rec_valid_i = 1'b0;
        end
        n = 0;
        while (!seen_done && halted_o !== 1'b1 && n < LIM) begin
            @(negedge clk_i);
            n++;
        end
        bound(n);
    endtask
    task automatic t_bad_baud;
        baud_code_i = 8'h77;
        go(0, 8'h5e, 8'hbb);
        chk("halted", 16'h0001, {15'h0, halted_o});
        chk("err_code", {8'h00, BYTE_ERR_BAUD}, {8'h00, err_code_o});
        baud_code_i = 8'h18;
    endtask
    task automatic t_bad_cmd;
        reject = 1'b1;
        go(0, 8'h5e, 8'hbb);
        chk("halted", 16'h0001, {15'h0, halted_o});
        chk("err_code", {8'h00, BYTE_ERR_CMD}, {8'h00, err_code_o});
        reject = 1'b0;
    endtask
    task automatic t_bad_pw;
        go(1, 8'ha5, 8'hbb);
        chk("halted", 16'h0001, {15'h0, halted_o});
        chk("err_code", 16'h0000, {8'h00, err_code_o});
    endtask
    task automatic t_bad_rec;
        go(1, 8'h5e, 8'hbc);
        chk("done", 16'h0000, {15'h0, seen_done});
        chk("err_code", 16'h0000, {8'h00, err_code_o});
    endtask
    task automatic t_keep;
        baud_code_i = BYTE_BAUD_INIT;
        baud_div_i = 16'h0010;
        go(1, 8'h5e, 8'hbb);
        chk("done", 16'h0001, {15'h0, seen_done});
        chk("sum", 16'h0033, sum_o);
        reject = 1'b1;
        go(0, 8'h5e, 8'hbb);
        chk("halted", 16'h0001, {15'h0, halted_o});
        chk("err_code", {8'h00, BYTE_ERR_CMD}, {8'h00, err_code_o});
        reject = 1'b0;
        baud_code_i = 8'h18;
        baud_div_i = 16'h0008;
    endtask
    task automatic t_write;
        go(1, 8'h5e, 8'hbb);
        chk("done", 16'h0001, {15'h0, seen_done});
        chk("sum", 16'h0033, sum_o);
    endtask
    task automatic t_again;
        go(1, 8'h5e, 8'hbb);
        chk("done", 16'h0001, {15'h0, seen_done});
        chk("halted", 16'h0000, {15'h0, halted_o});
    endtask
    task automatic t_blank;
        blank_i = 1'b1;
        lag = 8'h64;
        go(1, 8'h5e, 8'hbb);
        chk("done", 16'h0001, {15'h0, seen_done});
        chk("pw_ready", 16'h0000, {15'h0, seen_pw});
        pw_count_addr_i = 16'h0121;
        go(1, 8'h5e, 8'hbb);
        chk("halted", 16'h0001, {15'h0, halted_o});
        pw_count_addr_i = 16'h0120;
        blank_i = 1'b0;
    endtask
    initial begin
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_bad_baud;
        t_bad_cmd;
        t_bad_pw;
        t_bad_rec;
        t_keep;
        t_write;
        t_again;
        t_blank;
        end_of_test;
    end
endmodule // test_sfw_host
